// ### hw/dlt_target.sv
// Die link target: 4-bit link slave on its own clock, register access into a
// 256-byte window, supply warning status register and the link interrupt.
// Assumes the initiator drives the link clock and keeps it running through the
// last answer nibble (status, then read data) and one tick more, and that pull-downs sit on the data wires.
`default_nettype none
`include "dlt_defines.svh"

// Functional notes
// R1: Bit4 shows regulator overvoltage on either regulator
// R2: Reading offset 0x05 clears overvoltage flag
// R3: Bit3 high temperature; read clears its flag
// R4: Bit2 secondary high voltage; read clears flag
// R5: Bit1 primary low voltage; read clears flag
// R6: Bit0 low battery; read clears its flag
// R7: Upper bits zero, reset zero, writes ignored
// R8: Offsets relative to initiator bases 0x0200/0x300
// R9: Write: command, 8-bit address, then data
// R10: Read: command, address, target returns data
// R11: Full 256-byte window decoded
// R12: Blocking read/write, non-blocking write only
// R13: Link data bus is four bits wide
// R14: Target syncs when initiator starts clocking
// R15: Transaction, error status and end acknowledge
// R16: All interrupts on one output line
// R17: Link logic disabled in Sleep mode
// R18: Stop mode: interrupt line wakes controller
// R19: Wake command in Stop is wake event
// R20: Link clock is input only, initiator driven
// R21: Data pins bidirectional, interrupt output only
// R22: Sleep mode drives data pins low
// R23: Interrupt active high until acknowledged, Normal
// R24: Five supply flags form one interrupt source
module dlt_target (
   input wire logic mclk_i,                // System clock, 50 MHz
   input wire logic rst_i,                 // Asynchronous reset, active high
   input wire dlt_pkg::dlt_mode_t mode_i,  // Operating mode from mode control
   input wire logic ov_core_i,             // Core regulator overvoltage warning
   input wire logic ov_io_i,               // I/O regulator overvoltage warning
   input wire logic high_temp_i,           // Regulator high-temperature warning
   input wire logic high_volt_i,           // Secondary supply high-voltage warning
   input wire logic low_volt_i,            // Primary supply low-voltage warning
   input wire logic low_batt_i,            // Battery sense low warning
   input wire logic ext_irq_i,             // Other analog-die interrupt sources
   output logic [7:0] per_addr_o,          // Peripheral register offset
   output logic [7:0] per_wdata_o,         // Peripheral write data
   output logic per_wr_o,                  // Peripheral write strobe
   output logic per_rd_o,                  // Peripheral read strobe
   input wire logic [7:0] per_rdata_i,     // Peripheral read data, same cycle
   output logic wake_o,                    // Wake request to mode control
   input wire logic die_link_clock_i,      // Link clock from initiator
   input wire logic [3:0] die_link_data_i, // Link data pins, input side
   output logic [3:0] die_link_data_o,     // Link data pins, output side
   output logic die_link_data_oe_o,        // Link data output enable
   output logic die_link_interrupt_o       // Link interrupt / wake line
);
   import dlt_pkg::*;

   // ----------------------------------------------------------------
   // Synchroniser filter
   // ----------------------------------------------------------------
   // A bit moves only when second and third stages agree
   function automatic logic [6:0] dlt_filt(input logic [6:0] s2, input logic [6:0] s3, input logic [6:0] f);
      dlt_filt = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & f);
   endfunction : dlt_filt

   // ----------------------------------------------------------------
   // Link domain declarations
   // ----------------------------------------------------------------
   dlt_state_t st_q;
   logic [3:0] cmd_q;
   logic [7:0] addr_q;
   logic [7:0] wdata_q;
   logic [3:0] stat_q;
   logic [3:0] dout_q;
   logic oe_q;
   logic req_t_q;
   logic wake_t_q;
   logic xfer_rd_q;
   logic [7:0] xfer_addr_q;
   logic [7:0] xfer_wdata_q;
   logic [1:0] l_s1_q, l_s2_q, l_s3_q, l_f_q;
   logic [6:0] l_fnext;
   logic ack_l;
   logic sleep_l;
   logic busy_l;
   logic cmd_known;

   // ----------------------------------------------------------------
   // System domain declarations
   // ----------------------------------------------------------------
   logic [6:0] m_s1_q, m_s2_q, m_s3_q, m_f_q;
   logic [6:0] m_raw;
   logic [6:0] m_fnext;
   logic [4:0] cond_q;
   logic [4:0] rise;
   logic [4:0] flag_q, flag_d;
   logic ack_t_q;
   logic [7:0] rdata_q;
   logic err_q;
   logic sleep_q;
   logic irq_q;
   logic wake_q;
   logic req_m;
   logic access;
   logic hit_status;
   logic rd_status;
   logic wake_ev;
   logic [7:0] status_val;

   // ----------------------------------------------------------------
   // Warning conditions and interrupt flags
   // ----------------------------------------------------------------
   // Either regulator raises the overvoltage condition
   assign m_raw = {wake_t_q, req_t_q, ov_core_i | ov_io_i, high_temp_i, high_volt_i, low_volt_i, low_batt_i};  // [R1]
   assign m_fnext = dlt_filt(m_s2_q, m_s3_q, m_f_q);
   assign cond_q = m_f_q[4:0];
   assign rise = m_fnext[4:0] & ~m_f_q[4:0];
   assign req_m = m_f_q[5];
   assign wake_ev = m_fnext[6] ^ m_f_q[6];
   // Upper three bits stay zero; the lower five track the live conditions
   assign status_val = {3'h0, cond_q};  // [R1] [R3] [R4] [R5] [R6] [R7]
   // Window offset arrives already stripped of the initiator base
   assign hit_status = (xfer_addr_q == `DLT_OFS_SUPPLY_WARN);  // [R8] [R11]
   assign access = req_m ^ ack_t_q;
   assign rd_status = access & xfer_rd_q & hit_status;
   // A new warning edge wins over a clearing read in the same cycle
   assign flag_d = rise | (flag_q & ~{5{rd_status}});  // [R2] [R3] [R4] [R5] [R6]

   // Foreign-domain inputs pass three stages
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         m_s1_q <= 7'h00;
         m_s2_q <= 7'h00;
         m_s3_q <= 7'h00;
         m_f_q <= 7'h00;
         flag_q <= 5'h00;
      end else begin
         m_s1_q <= m_raw;
         m_s2_q <= m_s1_q;
         m_s3_q <= m_s2_q;
         m_f_q <= m_fnext;
         flag_q <= flag_d;
      end
   end

   // ----------------------------------------------------------------
   // Register access on the system side
   // ----------------------------------------------------------------
   // Peripheral port sees every offset except the status register
   assign per_addr_o = xfer_addr_q;
   assign per_wdata_o = xfer_wdata_q;
   assign per_rd_o = access & xfer_rd_q & ~hit_status;  // [R10] [R11]
   // Status register is read-only: a write there is dropped and flagged
   assign per_wr_o = access & ~xfer_rd_q & ~hit_status;  // [R7] [R9]

   // Transfer words are stable while the request toggle is in flight
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_t_q <= 1'b0;
         rdata_q <= `DLT_RST_SUPPLY_WARN;
         err_q <= 1'b0;
      end else if (access) begin
         ack_t_q <= req_m;
         rdata_q <= hit_status ? status_val : per_rdata_i;  // [R10]
         err_q <= hit_status & ~xfer_rd_q;  // [R15]
      end
   end

   // ----------------------------------------------------------------
   // Interrupt line, wake and sleep
   // ----------------------------------------------------------------
   // Line stays high until the flags are read away; silent in Sleep
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
         wake_q <= 1'b0;
         sleep_q <= 1'b0;
      end else begin
         irq_q <= (mode_i != `DLT_MODE_SLEEP) & ((|flag_q) | ext_irq_i);  // [R16] [R18] [R23] [R24]
         wake_q <= wake_ev & (mode_i == `DLT_MODE_STOP);  // [R19]
         sleep_q <= (mode_i == `DLT_MODE_SLEEP);  // [R17]
      end
   end
   assign die_link_interrupt_o = irq_q;  // [R21]
   assign wake_o = wake_q;

   // ----------------------------------------------------------------
   // Link side sequencer
   // ----------------------------------------------------------------
   assign l_fnext = dlt_filt({5'h00, l_s2_q}, {5'h00, l_s3_q}, {5'h00, l_f_q});
   assign ack_l = l_f_q[1];
   assign sleep_l = l_f_q[0];
   assign busy_l = (ack_l != req_t_q);
   assign cmd_known = (die_link_data_i == `DLT_CMD_WRITE) | (die_link_data_i == `DLT_CMD_READ) |
                      (die_link_data_i == `DLT_CMD_WRITE_NB);  // [R12]
   // Sleep forces the wires low at once from the system side, even with the link clock stopped
   assign die_link_data_o = (sleep_q | sleep_l) ? 4'h0 : dout_q;  // [R22]
   assign die_link_data_oe_o = sleep_q | sleep_l | oe_q;  // [R21] [R22]

   // Crossing from the system side into the link clock
   always_ff @(posedge die_link_clock_i or posedge rst_i) begin  // [R20]
      if (rst_i) begin
         l_s1_q <= 2'h0;
         l_s2_q <= 2'h0;
         l_s3_q <= 2'h0;
         l_f_q <= 2'h0;
      end else begin
         l_s1_q <= {ack_t_q, sleep_q};
         l_s2_q <= l_s1_q;
         l_s3_q <= l_s2_q;
         l_f_q <= l_fnext[1:0];
      end
   end

   // Frame engine; a nonzero nibble on an idle bus starts a frame, so no
   // training sequence is needed. The clock may stop between frames.
   always_ff @(posedge die_link_clock_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= DLT_IDLE;
         cmd_q <= 4'h0;
         addr_q <= 8'h00;
         wdata_q <= 8'h00;
         stat_q <= 4'h0;
         dout_q <= 4'h0;
         oe_q <= 1'b0;
         req_t_q <= 1'b0;
         wake_t_q <= 1'b0;
         xfer_rd_q <= 1'b0;
         xfer_addr_q <= 8'h00;
         xfer_wdata_q <= 8'h00;
      end else if (sleep_l) begin
         st_q <= DLT_IDLE;  // [R17]
         oe_q <= 1'b0;
         dout_q <= 4'h0;
      end else begin
         case (st_q)
            DLT_IDLE: begin
               oe_q <= 1'b0;
               dout_q <= 4'h0;
               cmd_q <= die_link_data_i;
               if (oe_q) begin  // Wires still show our own last answer nibble
                  st_q <= DLT_IDLE;
               end else if (die_link_data_i == `DLT_CMD_WAKE) begin
                  wake_t_q <= ~wake_t_q;  // [R19]
                  stat_q <= 4'h9;
                  st_q <= DLT_STAT;
               end else if (cmd_known) begin
                  st_q <= DLT_ADDR_H;  // [R14]
               end else if (die_link_data_i != 4'h0) begin
                  stat_q <= 4'hC;  // Unknown command: end with error
                  st_q <= DLT_STAT;
               end
            end
            DLT_ADDR_H: begin
               addr_q[7:4] <= die_link_data_i;  // [R13]
               st_q <= DLT_ADDR_L;
            end
            DLT_ADDR_L: begin
               addr_q[3:0] <= die_link_data_i;
               st_q <= (cmd_q == `DLT_CMD_READ) ? DLT_LAUNCH : DLT_DATA_H;  // [R9] [R10]
            end
            DLT_DATA_H: begin
               wdata_q[7:4] <= die_link_data_i;
               st_q <= DLT_DATA_L;
            end
            DLT_DATA_L: begin
               wdata_q[3:0] <= die_link_data_i;
               st_q <= DLT_LAUNCH;
            end
            // Hold the frame while an earlier posted write is still in flight
            DLT_LAUNCH: begin
               if (!busy_l) begin
                  req_t_q <= ~req_t_q;
                  xfer_rd_q <= (cmd_q == `DLT_CMD_READ);
                  xfer_addr_q <= addr_q;
                  xfer_wdata_q <= wdata_q;
                  if (cmd_q == `DLT_CMD_WRITE_NB) begin
                     stat_q <= 4'h9;  // [R12]
                     st_q <= DLT_STAT;
                  end else begin
                     st_q <= DLT_WAIT;
                  end
               end
            end
            DLT_WAIT: begin
               if (!busy_l) begin
                  stat_q <= {1'b1, err_q, xfer_rd_q, ~err_q};  // [R15]
                  st_q <= DLT_STAT;
               end
            end
            DLT_STAT: begin
               oe_q <= 1'b1;
               dout_q <= stat_q;  // [R15]
               st_q <= stat_q[`DLT_STAT_RD] ? DLT_RD_H : DLT_IDLE;
            end
            DLT_RD_H: begin
               dout_q <= rdata_q[7:4];  // [R10]
               st_q <= DLT_RD_L;
            end
            DLT_RD_L: begin
               dout_q <= rdata_q[3:0];
               st_q <= DLT_IDLE;
            end
            default: begin
               st_q <= DLT_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_ov_bit;
      @(posedge mclk_i) disable iff (rst_i) (ov_core_i | ov_io_i) [*5] |-> status_val[`DLT_BIT_REG_OV];
   endproperty
   a_ov_bit: assert property (p_ov_bit) else $error("overvoltage bit missing");  // [R1]
   property p_rd_clear;
      @(posedge mclk_i) disable iff (rst_i) rd_status && !rise[`DLT_BIT_REG_OV] |=> !flag_q[`DLT_BIT_REG_OV];
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read did not clear flag");  // [R2]
   property p_temp_set;
      @(posedge mclk_i) disable iff (rst_i) rise[`DLT_BIT_HIGH_TEMP] |=> flag_q[`DLT_BIT_HIGH_TEMP];
   endproperty
   a_temp_set: assert property (p_temp_set) else $error("temperature flag lost");  // [R3]
   property p_batt_low;
      @(posedge mclk_i) disable iff (rst_i) (!low_batt_i) [*5] |-> !status_val[`DLT_BIT_LOW_BATT];
   endproperty
   a_batt_low: assert property (p_batt_low) else $error("battery bit stuck");  // [R6]
   property p_no_wr;
      @(posedge mclk_i) disable iff (rst_i) per_wr_o |-> per_addr_o != `DLT_OFS_SUPPLY_WARN;
   endproperty
   a_no_wr: assert property (p_no_wr) else $error("write reached status register");  // [R7]
   property p_irq;
      @(posedge mclk_i) disable iff (rst_i) (|flag_q) && mode_i == `DLT_MODE_NORMAL |=> die_link_interrupt_o;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");  // [R23]
   property p_irq_sleep;
      @(posedge mclk_i) disable iff (rst_i) mode_i == `DLT_MODE_SLEEP |=> !die_link_interrupt_o;
   endproperty
   a_irq_sleep: assert property (p_irq_sleep) else $error("interrupt in sleep");  // [R16]
   property p_wake;
      @(posedge mclk_i) disable iff (rst_i) wake_ev && mode_i == `DLT_MODE_STOP |=> wake_o;
   endproperty
   a_wake: assert property (p_wake) else $error("wake command lost");  // [R19]
   property p_sleep_pins;
      @(posedge die_link_clock_i) disable iff (rst_i) sleep_l |-> die_link_data_oe_o && die_link_data_o == 4'h0;
   endproperty
   a_sleep_pins: assert property (p_sleep_pins) else $error("pins not low in sleep");  // [R22]
   property p_eot;
      @(posedge die_link_clock_i) disable iff (rst_i) st_q == DLT_STAT && !sleep_l |=> oe_q && dout_q[`DLT_STAT_EOT];
   endproperty
   a_eot: assert property (p_eot) else $error("status nibble lacks end flag");  // [R15]
   property p_read_seq;
      @(posedge die_link_clock_i) disable iff (rst_i)
         st_q == DLT_WAIT && !busy_l && xfer_rd_q && !sleep_l [*1] ##1 !sleep_l [*3] |->
         $past(st_q) == DLT_RD_H && st_q == DLT_RD_L;
   endproperty
   a_read_seq: assert property (p_read_seq) else $error("read data not returned");  // [R10]
   c_read: cover property (@(posedge die_link_clock_i) disable iff (rst_i) st_q == DLT_RD_L);
   c_post: cover property (@(posedge die_link_clock_i) disable iff (rst_i)
      st_q == DLT_LAUNCH && cmd_q == `DLT_CMD_WRITE_NB && !busy_l);
   c_wake: cover property (@(posedge mclk_i) disable iff (rst_i) wake_o);
   c_clear: cover property (@(posedge mclk_i) disable iff (rst_i) rd_status && (|flag_q));
endmodule : dlt_target
`default_nettype wire

// ### include/dlt_defines.svh
// Constants of the die link target: register offsets, field positions,
// reset values, mode codes, link command codes and status nibble layout.
// Assumes inclusion by bare name from the package and the design.
`ifndef DLT_DEFINES_SVH
`define DLT_DEFINES_SVH
// Initiator-side bases of the 256-byte window (blocking / non-blocking)
`define DLT_BASE_BLOCKING 16'h0200
`define DLT_BASE_NONBLOCK 16'h0300
// Register offsets inside the window
`define DLT_OFS_SUPPLY_WARN 8'h05
`define DLT_RST_SUPPLY_WARN 8'h00
// Field positions of supply_warning_status
`define DLT_BIT_REG_OV 4
`define DLT_BIT_HIGH_TEMP 3
`define DLT_BIT_HIGH_VOLT 2
`define DLT_BIT_LOW_VOLT 1
`define DLT_BIT_LOW_BATT 0
// Operating modes from mode control
`define DLT_MODE_NORMAL 2'h0
`define DLT_MODE_STOP 2'h1
`define DLT_MODE_SLEEP 2'h2
// Link command nibbles; all nonzero so the pulled-down idle bus reads as no command
`define DLT_CMD_WRITE 4'h1
`define DLT_CMD_READ 4'h2
`define DLT_CMD_WRITE_NB 4'h3
`define DLT_CMD_WAKE 4'h5
// Status nibble bits
`define DLT_STAT_EOT 3
`define DLT_STAT_ERR 2
`define DLT_STAT_RD 1
`define DLT_STAT_OK 0
// Synchroniser depth for inputs from a foreign domain
`define DLT_SYNC_DEPTH 3
`endif

// ### include/dlt_pkg.sv
// Types of the die link target.
// Assumes dlt_defines.svh is on the include path.
`default_nettype none
package dlt_pkg;
   `include "dlt_defines.svh"
   // Link-side sequencer, one-hot
   typedef enum logic [9:0] {
      DLT_IDLE   = 10'h001,
      DLT_ADDR_H = 10'h002,
      DLT_ADDR_L = 10'h004,
      DLT_DATA_H = 10'h008,
      DLT_DATA_L = 10'h010,
      DLT_LAUNCH = 10'h020,
      DLT_WAIT   = 10'h040,
      DLT_STAT   = 10'h080,
      DLT_RD_H   = 10'h100,
      DLT_RD_L   = 10'h200
   } dlt_state_t;
   typedef logic [1:0] dlt_mode_t;
endpackage : dlt_pkg
`default_nettype wire

// ### tb/dlt_initiator.sv
// Initiator model of the die link: makes the link clock, sends nibbles.
// Assumes the bench resolves the data wires, pull-down when nobody drives.
`default_nettype none
module dlt_initiator (
   input wire logic [3:0] bus_i, // Resolved data wires
   input wire logic oe_i,        // Target drives the wires
   output logic clk_o,           // Link clock, still between frames
   output logic drv_o,           // Initiator drives the wires
   output logic [3:0] nib_o      // Nibble put out by the initiator
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      clk_o = 1'b0;
      drv_o = 1'b0;
      nib_o = 4'h0;
   end
   // ----------------------------------------
   // One link clock of 48 ns
   // ----------------------------------------
   task automatic tick();
      #24 clk_o = 1'b1;
      #24 clk_o = 1'b0;
   endtask : tick
   // Frame: request nibbles, release, wait for the end nibble under a bound
   task automatic xfer(input logic [3:0] cmd, input logic [7:0] adr, input logic [7:0] wd,
                       input int nreq, output logic [3:0] st, output logic [7:0] rd);
      logic [3:0] req [5];
      req = '{cmd, adr[7:4], adr[3:0], wd[7:4], wd[3:0]};
      st = 4'h0;
      rd = 8'h00;
      drv_o = 1'b1;
      for (int i = 0; i < nreq; i++) begin
         nib_o = req[i];
         tick();
      end
      // Released wires fall to the pull-down, so the target sees no command
      drv_o = 1'b0;
      nib_o = 4'h0;
      for (int n = 0; n < 64 && st == 4'h0; n++) begin
         tick();
         if (oe_i && bus_i[3]) st = bus_i;
      end
      if (st[1]) begin
         tick();
         rd[7:4] = bus_i;
         tick();
         rd[3:0] = bus_i;
      end
      if (st != 4'h0) tick();
   endtask : xfer
endmodule : dlt_initiator
`default_nettype wire

// ### tb/die_link_target_status_bench.sv
// Bench of the die link target: register access over the link, supply flags,
// interrupt line, modes. Assumes dlt_initiator and the design are compiled first.
`default_nettype none
`include "dlt_defines.svh"
module die_link_target_status_bench;
   import dlt_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   dlt_mode_t mode = `DLT_MODE_NORMAL;
   logic [5:0] warn = 6'h00;
   logic ext_irq = 1'b0;
   logic [7:0] per_addr, per_wdata, wr_adr, wr_dat, rdv;
   logic [7:0] per_rdata = 8'h00;
   logic per_wr, per_rd, wake, lclk, oe, irq, ini_drv;
   logic [3:0] dout, ini_nib, link_bus, st;
   int checks = 0;
   int bad_count = 0;
   int wr_seen = 0;
   int rd_seen = 0;
   int wake_cnt = 0;
   always #10 mclk = ~mclk;
   // Wire level: target wins, else initiator, else pull-down
   assign link_bus = oe ? dout : (ini_drv ? ini_nib : 4'h0);
   dlt_target DUT (.mclk_i(mclk), .rst_i(rst), .mode_i(mode), .ov_core_i(warn[4]), .ov_io_i(warn[5]),
      .high_temp_i(warn[3]), .high_volt_i(warn[2]), .low_volt_i(warn[1]), .low_batt_i(warn[0]),
      .ext_irq_i(ext_irq), .per_addr_o(per_addr), .per_wdata_o(per_wdata), .per_wr_o(per_wr),
      .per_rd_o(per_rd), .per_rdata_i(per_rdata), .wake_o(wake), .die_link_clock_i(lclk),
      .die_link_data_i(link_bus), .die_link_data_o(dout), .die_link_data_oe_o(oe),
      .die_link_interrupt_o(irq));
   dlt_initiator INI (.bus_i(link_bus), .oe_i(oe), .clk_o(lclk), .drv_o(ini_drv), .nib_o(ini_nib));
   // Peripheral stand-in: read data derived from the offset, strobes logged
   always @(posedge mclk) begin
      per_rdata <= per_addr ^ 8'h5A;
      if (per_wr) begin
         wr_seen <= wr_seen + 1;
         wr_adr <= per_addr;
         wr_dat <= per_wdata;
      end
      if (wake) wake_cnt <= wake_cnt + 1;
      if (per_rd) rd_seen <= rd_seen + 1;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : wait_clk
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      INI.xfer(`DLT_CMD_READ, a, 8'h00, 3, st, d);
      check({4'h0, st}, 8'h0B, "read status");
      check({7'h0, oe}, 8'h00, "wires released");
   endtask : rd_reg
   task automatic wr_reg(input logic [3:0] c, input logic [7:0] a, input logic [7:0] d, input logic [3:0] e);
      INI.xfer(c, a, d, 5, st, rdv);
      check({4'h0, st}, {4'h0, e}, "write status");
   endtask : wr_reg
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   // Watchdog, well beyond the few tens of microseconds the tests need
   initial begin
      #500us;
      bad_count++;
      test_done();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      fork
         repeat (3) INI.tick();
         repeat (12) @(posedge mclk);
      join
      @(posedge mclk) rst <= 1'b0;
      repeat (4) INI.tick();
      wait_clk(4);
      rd_reg(`DLT_OFS_SUPPLY_WARN, rdv);
      check(rdv, `DLT_RST_SUPPLY_WARN, "status reset");
      wr_reg(`DLT_CMD_WRITE, `DLT_OFS_SUPPLY_WARN, 8'hFF, 4'hC);
      rd_reg(`DLT_OFS_SUPPLY_WARN, rdv);
      check(rdv, 8'h00, "status after write");
      // Each warning alone: its bit, the shared interrupt, cleared by a read
      for (int i = 0; i < 6; i++) begin
         @(posedge mclk) warn <= 6'h01 << i;
         wait_clk(8);
         check({7'h0, irq}, 8'h01, "irq on warning");
         rd_reg(`DLT_OFS_SUPPLY_WARN, rdv);
         check(rdv, (i < 5) ? (8'h01 << i) : 8'h10, "status bit");
         wait_clk(4);
         check({7'h0, irq}, 8'h00, "irq after read");
         @(posedge mclk) warn <= 6'h00;
         wait_clk(8);
         rd_reg(`DLT_OFS_SUPPLY_WARN, rdv);
         check(rdv, 8'h00, "status gone");
      end
      // Peripheral writes, blocking and posted, at the window edges
      wr_reg(`DLT_CMD_WRITE, 8'hFF, 8'hA5, 4'h9);
      wait_clk(10);
      check(wr_adr, 8'hFF, "write offset");
      check(wr_dat, 8'hA5, "write data");
      wr_reg(`DLT_CMD_WRITE_NB, 8'h00, 8'h3C, 4'h9);
      wait_clk(12);
      check(wr_adr, 8'h00, "posted offset");
      check(wr_dat, 8'h3C, "posted data");
      check(wr_seen[7:0], 8'h02, "write strobes");
      rd_reg(8'h80, rdv);
      check(rdv, 8'hDA, "peripheral read");
      check(rd_seen[7:0], 8'h01, "read strobes");
      INI.xfer(4'h4, 8'h00, 8'h00, 1, st, rdv);
      check({4'h0, st}, 8'h0C, "unknown command");
      INI.xfer(`DLT_CMD_WAKE, 8'h00, 8'h00, 1, st, rdv);
      check({4'h0, st}, 8'h09, "wake status normal");
      wait_clk(8);
      check(wake_cnt[7:0], 8'h00, "no wake in normal");
      @(posedge mclk) ext_irq <= 1'b1;
      wait_clk(3);
      check({7'h0, irq}, 8'h01, "other source irq");
      // Stop: wake command and the wake line
      @(posedge mclk) mode <= `DLT_MODE_STOP;
      wait_clk(3);
      check({7'h0, irq}, 8'h01, "wake line in stop");
      INI.xfer(`DLT_CMD_WAKE, 8'h00, 8'h00, 1, st, rdv);
      check({4'h0, st}, 8'h09, "wake status");
      wait_clk(8);
      check(wake_cnt[7:0], 8'h01, "wake pulse");
      // Sleep: wires held low, link ignored, no interrupt
      @(posedge mclk) mode <= `DLT_MODE_SLEEP;
      wait_clk(4);
      check({3'h0, oe, dout}, 8'h10, "sleep wires");
      check({7'h0, irq}, 8'h00, "irq in sleep");
      INI.xfer(`DLT_CMD_WRITE, 8'h11, 8'h22, 5, st, rdv);
      wait_clk(8);
      check({4'h0, st}, 8'h00, "no answer in sleep");
      check(wr_seen[7:0], 8'h02, "no write in sleep");
      @(posedge mclk) mode <= `DLT_MODE_NORMAL;
      ext_irq <= 1'b0;
      wait_clk(8);
      repeat (4) INI.tick();
      rd_reg(`DLT_OFS_SUPPLY_WARN, rdv);
      check(rdv, 8'h00, "status after sleep");
      test_done();
   end
endmodule : die_link_target_status_bench
`default_nettype wire
